// ---- rtl/byte_ram.sv ----
/*
  Small byte memory with registered read data.
  Assumes one write port and one read port on the same clock.
*/
`timescale 1ns/1ps
module byte_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule : byte_ram

// ---- rtl/sync3.sv ----
/*
  Three-stage input synchroniser with agreement filter.
  Assumes an asynchronous level input; output changes when stages two and three agree.
*/
`timescale 1ns/1ps
module sync3 (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic rst_val_i,
  input  wire logic async_i,
  output logic      level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_i) begin
    s1_q <= async_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (sys_rst_i) begin
      level_o <= rst_val_i;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end
endmodule : sync3

// ---- rtl/uart_front_pkg.sv ----
/*
  Shared constants for one UART channel front end.
  Assumes a host-side serial slave that delivers decoded register strobes.
*/
// How it works
// - Reading offset zero returns the oldest receive byte and pops it.
// - Reading an empty receive buffer gives junk and changes nothing.
// - Writing offset zero appends the byte to the transmit buffer tail.
// - A write into a full transmit buffer is dropped.
// - Offset zero is the divisor low byte only when line_control[7] set and not BF.
// - Divisor low byte defaults to 01, cleared only by power-on reset.
// - Enable bit 7 gates CTS and DSR change interrupts.
// - Enable bit 6 gates RTS and DTR interrupts.
// - Enable bit 5 gates the Xoff or special character interrupt.
// - Enable bit 4 with enhanced mode permits sleep when everything is quiet.
// - Sleep ends on modem toggle, receive line low, or transmit load.
// - While asleep the oscillator stops and the channel clock is gated.
// - Enable bit 3 gates the modem status interrupt.
// - Enable bit 2 gates the receiver line status interrupt.
// - Enable bit 1 gates transmit ready: empty, or free space above trigger.
// - Enable bit 0 gates the receive data ready interrupt.
// - Upper four enable bits change only with enhanced mode set.
package uart_front_pkg;
  localparam logic [3:0] OFS_HOLDING   = 4'h0;
  localparam logic [3:0] OFS_ENABLES   = 4'h1;
  localparam logic [7:0] LC_LOCK_CODE  = 8'hBF;
  localparam int         LC_DIV_BIT    = 7;
  localparam logic [7:0] DIV_LOW_RESET = 8'h01;
  localparam logic [7:0] EN_RESET      = 8'h00;
  localparam logic [7:0] EN_LOW_MASK   = 8'h0F;
  localparam int         EN_RX_READY   = 0;
  localparam int         EN_TX_READY   = 1;
  localparam int         EN_LINE_ERR   = 2;
  localparam int         EN_MODEM      = 3;
  localparam int         EN_SLEEP      = 4;
  localparam int         EN_XOFF       = 5;
  localparam int         EN_RTS_DTR    = 6;
  localparam int         EN_CTS_DSR    = 7;
  localparam int         SUB_REG_LSB   = 3;
  localparam int         SUB_CHAN_LSB  = 1;
  localparam int         FIFO_DEPTH    = 64;
endpackage : uart_front_pkg

// ---- rtl/uart_holding_and_int_enable.sv ----
/*
  Holding ports, divisor low byte and interrupt enables of one UART channel.
  Assumes the serial slave decodes the sub-address and gives one-cycle read and
  write strobes; interrupt sources, line control and enhanced mode come from
  neighbouring blocks on the same clock.
*/
`timescale 1ns/1ps
module uart_holding_and_int_enable
  import uart_front_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          soft_rst_i,
  input  wire logic [7:0]    sub_addr_i,
  input  wire logic [1:0]    chan_id_i,
  input  wire logic          reg_rd_i,
  input  wire logic          reg_wr_i,
  input  wire logic [7:0]    reg_wdata_i,
  output logic      [7:0]    reg_rdata_o,
  output logic               reg_rvalid_o,
  output logic               wr_nack_o,
  input  wire logic [7:0]    line_control_i,
  input  wire logic          enh_enable_i,
  input  wire logic          fifo_mode_i,
  input  wire logic [6:0]    tx_trigger_i,
  input  wire logic          rx_push_i,
  input  wire logic [7:0]    rx_byte_i,
  input  wire logic          tx_pop_i,
  output logic      [7:0]    tx_byte_o,
  output logic               tx_valid_o,
  output logic      [AW:0]   rx_level_o,
  output logic      [AW:0]   tx_level_o,
  input  wire logic          src_rx_ready_i,
  input  wire logic          src_line_err_i,
  input  wire logic          src_modem_i,
  input  wire logic          src_xoff_i,
  input  wire logic          src_rts_dtr_i,
  input  wire logic          src_cts_dsr_i,
  input  wire logic          int_pending_i,
  input  wire logic          rx_pin_i,
  input  wire logic [3:0]    modem_pins_i,
  output logic      [7:0]    divisor_low_o,
  output logic      [7:0]    int_enables_o,
  output logic               int_req_rx_ready_o,
  output logic               int_req_tx_ready_o,
  output logic               int_req_line_err_o,
  output logic               int_req_modem_o,
  output logic               int_req_xoff_o,
  output logic               int_req_rts_dtr_o,
  output logic               int_req_cts_dsr_o,
  output logic               asleep_o,
  output logic               osc_enable_o,
  output logic               chan_clk_en_o
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {AWAKE, ASLEEP} power_t;

  wire       clear_all  = sys_rst_i | soft_rst_i;
  wire [3:0] reg_sel    = sub_addr_i[SUB_REG_LSB +: 4];
  wire [1:0] chan_sel   = sub_addr_i[SUB_CHAN_LSB +: 2];
  wire       lc_div     = line_control_i[LC_DIV_BIT];
  wire       chan_hit   = (chan_sel == chan_id_i);
  wire       div_window = lc_div && (line_control_i != LC_LOCK_CODE);
  wire       hold_sel   = chan_hit && (reg_sel == OFS_HOLDING);
  wire       en_sel     = chan_hit && (reg_sel == OFS_ENABLES) && !lc_div;
  wire       div_wr     = reg_wr_i && hold_sel && div_window;
  wire       hold_wr    = reg_wr_i && hold_sel && !lc_div;
  wire       hold_rd    = reg_rd_i && hold_sel && !lc_div;
  wire       en_wr      = reg_wr_i && en_sel;
  wire       en_rd      = reg_rd_i && en_sel;

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  logic [AW:0]   rx_cnt_q;
  logic [AW-1:0] rx_wp_q;
  logic [AW-1:0] rx_rp_q;
  logic [7:0]    rx_rdata;

  wire rx_empty = (rx_cnt_q == '0);
  wire rx_full  = (rx_cnt_q == (AW+1)'(DEPTH));
  wire rx_pop   = hold_rd && !rx_empty;
  wire rx_push  = rx_push_i && !rx_full;

  byte_ram #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) rx_ram (
    .clk_i     (clk_i),
    .wr_en_i   (rx_push),
    .wr_addr_i (rx_wp_q),
    .wr_data_i (rx_byte_i),
    .rd_addr_i (rx_rp_q),
    .rd_data_o (rx_rdata)
  );

  // Receive buffer flush on either reset.
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      rx_wp_q <= '0;
    end else if (rx_push) begin
      rx_wp_q <= rx_wp_q + 1'b1;
    end
  end

  // The read port always shows the head, so an empty read returns stale data.
  // Pop oldest byte.
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      rx_rp_q <= '0;
    end else if (rx_pop) begin
      rx_rp_q <= rx_rp_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      rx_cnt_q <= '0;
    end else begin
      rx_cnt_q <= rx_cnt_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  logic [AW:0]   tx_cnt_q;
  logic [AW-1:0] tx_wp_q;
  logic [AW-1:0] tx_rp_q;
  logic [7:0]    tx_rdata;

  wire tx_empty = (tx_cnt_q == '0);
  wire tx_full  = (tx_cnt_q == (AW+1)'(DEPTH));
  wire tx_push  = hold_wr && !tx_full;
  wire tx_pop   = tx_pop_i && !tx_empty;
  // The read port is registered, so the pointer must lead by the pop itself.
  wire [AW-1:0] tx_rd_addr = tx_pop ? tx_rp_q + 1'b1 : tx_rp_q;

  byte_ram #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) tx_ram (
    .clk_i     (clk_i),
    .wr_en_i   (tx_push),
    .wr_addr_i (tx_wp_q),
    .wr_data_i (reg_wdata_i),
    .rd_addr_i (tx_rd_addr),
    .rd_data_o (tx_rdata)
  );

  logic tx_fresh_q;

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      tx_wp_q <= '0;
    end else if (tx_push) begin
      tx_wp_q <= tx_wp_q + 1'b1;
    end
  end

  // Transmit buffer flush on either reset.
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      tx_rp_q <= '0;
    end else if (tx_pop) begin
      tx_rp_q <= tx_rp_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      tx_cnt_q   <= '0;
      tx_fresh_q <= 1'b0;
    end else begin
      tx_cnt_q   <= tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      tx_fresh_q <= tx_push || tx_pop;
    end
  end

  // A byte written into an empty buffer needs one cycle to reach the read port.
  assign tx_valid_o = !tx_empty && !(tx_fresh_q && tx_cnt_q == (AW+1)'(1));
  assign tx_byte_o  = tx_rdata;
  assign rx_level_o = rx_cnt_q;
  assign tx_level_o = tx_cnt_q;
  assign wr_nack_o  = hold_wr && tx_full;

  // ----------------------------------------------------------------
  // Divisor low byte and interrupt enables
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  logic [7:0] en_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_q <= DIV_LOW_RESET;
    end else if (div_wr) begin
      div_q <= reg_wdata_i;
    end
  end

  // Upper nibble locked without enhanced mode.
  wire [7:0] en_keep = enh_enable_i ? 8'h00 : ~EN_LOW_MASK;
  wire [7:0] en_d    = (en_q & en_keep) | (reg_wdata_i & ~en_keep);

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      en_q <= EN_RESET;
    end else if (en_wr) begin
      en_q <= en_d;
    end
  end

  assign divisor_low_o = div_q;
  assign int_enables_o = en_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Reading the divisor window returns zero because that byte is write-only.
  wire [7:0] rd_mux = en_rd ? en_q : 8'h00;
  logic       hold_rd_q;
  logic       rd_q;
  logic [7:0] rd_hold_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hold_rd_q <= 1'b0;
      rd_q      <= 1'b0;
      rd_hold_q <= 8'h00;
    end else begin
      hold_rd_q <= hold_rd;
      rd_q      <= reg_rd_i;
      rd_hold_q <= rd_mux;
    end
  end

  assign reg_rdata_o  = hold_rd_q ? rx_rdata : rd_hold_q;
  assign reg_rvalid_o = rd_q;

  // ----------------------------------------------------------------
  // Interrupt gating
  // ----------------------------------------------------------------
  // Transmit ready by mode.
  wire tx_space_hit = ((AW+1)'(DEPTH) - tx_cnt_q) > (AW+1)'(tx_trigger_i);
  wire tx_ready     = fifo_mode_i ? tx_space_hit : tx_empty;

  assign int_req_rx_ready_o = en_q[EN_RX_READY] && src_rx_ready_i;
  assign int_req_tx_ready_o = en_q[EN_TX_READY] && tx_ready;
  assign int_req_line_err_o = en_q[EN_LINE_ERR] && src_line_err_i;
  assign int_req_modem_o    = en_q[EN_MODEM] && src_modem_i;
  assign int_req_xoff_o     = en_q[EN_XOFF] && src_xoff_i;
  assign int_req_rts_dtr_o  = en_q[EN_RTS_DTR] && src_rts_dtr_i;
  assign int_req_cts_dsr_o  = en_q[EN_CTS_DSR] && src_cts_dsr_i;

  // ----------------------------------------------------------------
  // Sleep control
  // ----------------------------------------------------------------
  logic       rx_level;
  logic [3:0] modem_level;
  logic [3:0] modem_last_q;

  sync3 rx_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .rst_val_i (1'b1),
    .async_i   (rx_pin_i),
    .level_o   (rx_level)
  );

  for (genvar i = 0; i < 4; i++) begin : g_modem
    sync3 modem_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .rst_val_i (1'b0),
      .async_i   (modem_pins_i[i]),
      .level_o   (modem_level[i])
    );
  end

  // A false toggle right after reset is harmless: the enables are clear then.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      modem_last_q <= 4'h0;
    end else begin
      modem_last_q <= modem_level;
    end
  end

  wire modem_toggle = |(modem_level ^ modem_last_q);
  wire may_sleep = en_q[EN_SLEEP] && enh_enable_i && !int_pending_i && !modem_toggle
                   && rx_level && rx_empty && tx_empty;
  wire wake = modem_toggle || !rx_level || hold_wr;

  power_t pwr_q;

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      pwr_q <= AWAKE;
    end else begin
      unique case (pwr_q)
        AWAKE: begin
          if (may_sleep && !wake) begin
            pwr_q <= ASLEEP;
          end
        end
        ASLEEP: begin
          if (wake || !en_q[EN_SLEEP]) begin
            pwr_q <= AWAKE;
          end
        end
        default: begin
          pwr_q <= AWAKE;
        end
      endcase
    end
  end

  // The register clock keeps running so that a host write can always wake the channel.
  // Stop oscillator and gate clock.
  assign asleep_o      = (pwr_q == ASLEEP);
  assign osc_enable_o  = (pwr_q != ASLEEP);
  assign chan_clk_en_o = (pwr_q != ASLEEP);
endmodule : uart_holding_and_int_enable

// ---- test/host_model.sv ----
/*
  Host processor model issuing decoded register accesses.
  Assumes the front end takes one-cycle strobes at the rising edge.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_i,
  input  wire logic       wr_nack_i,
  output logic      [7:0] sub_addr_o,
  output logic            reg_rd_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o
);
  initial begin
    sub_addr_o  = 8'h00;
    reg_rd_o    = 1'b0;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // ------------------------------
  // Access
  // ------------------------------
  task automatic access(input logic rd, input logic [3:0] ofs, input logic [7:0] d,
                        input logic [1:0] ch, output logic nack);
    repeat ($urandom_range(0, 2)) @(posedge clk_i);
    sub_addr_o  <= {1'b0, ofs, ch, 1'b0};
    reg_rd_o    <= rd;
    reg_wr_o    <= !rd;
    reg_wdata_o <= d;
    @(negedge clk_i);
    nack = wr_nack_i;
    @(posedge clk_i);
    // Released fields flip so a stale value never looks live.
    sub_addr_o  <= ~sub_addr_o;
    reg_wdata_o <= ~reg_wdata_o;
    reg_rd_o    <= 1'b0;
    reg_wr_o    <= 1'b0;
    #1;
  endtask : access
endmodule : host_model

// ---- test/uart_front_checker.sv ----
/*
  Concurrent checks on the holding ports, divisor low byte and enables.
  Assumes a bind onto the channel front end with its strobe interface.
*/
`timescale 1ns/1ps
module uart_front_checker
  import uart_front_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        soft_rst_i,
  input wire logic [7:0]  sub_addr_i,
  input wire logic [1:0]  chan_id_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        wr_nack_o,
  input wire logic [7:0]  line_control_i,
  input wire logic        enh_enable_i,
  input wire logic        fifo_mode_i,
  input wire logic [6:0]  tx_trigger_i,
  input wire logic        rx_push_i,
  input wire logic        tx_pop_i,
  input wire logic [AW:0] rx_level_o,
  input wire logic [AW:0] tx_level_o,
  input wire logic [7:0]  divisor_low_o,
  input wire logic [7:0]  int_enables_o,
  input wire logic        int_req_tx_ready_o,
  input wire logic        asleep_o,
  input wire logic        osc_enable_o,
  input wire logic        chan_clk_en_o
);
  // ------------------------------
  // Decode
  // ------------------------------
  wire       hit  = sub_addr_i[2:1] == chan_id_i && !soft_rst_i;
  wire [3:0] ofs  = sub_addr_i[6:3];
  wire       lc7  = line_control_i[LC_DIV_BIT];
  wire       h0   = hit && ofs == OFS_HOLDING && !lc7;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence tx_wr_s; reg_wr_i && h0 && !tx_pop_i; endsequence
  sequence rx_rd_s; reg_rd_i && h0 && !rx_push_i; endsequence
  // ------------------------------
  // Assertions
  // ------------------------------
  rx_pop_a: assert property (rx_rd_s ##0 rx_level_o != 0 |=>
    rx_level_o == $past(rx_level_o) - 1) else $error("receive level did not drop");
  rx_empty_a: assert property (rx_rd_s ##0 rx_level_o == 0 |=>
    rx_level_o == 0) else $error("empty receive read changed level");
  tx_push_a: assert property (tx_wr_s ##0 tx_level_o < DEPTH |=>
    tx_level_o == $past(tx_level_o) + 1) else $error("transmit level did not rise");
  tx_full_a: assert property (tx_wr_s ##0 tx_level_o == DEPTH |->
    wr_nack_o ##1 tx_level_o == DEPTH) else $error("full write not dropped");
  div_write_a: assert property (reg_wr_i && hit && ofs == OFS_HOLDING && lc7
    && line_control_i != LC_LOCK_CODE |=> divisor_low_o == $past(reg_wdata_i))
    else $error("divisor low byte not written");
  div_keep_a: assert property (soft_rst_i && !reg_wr_i |=> $stable(divisor_low_o))
    else $error("soft reset changed divisor");
  en_lock_a: assert property (reg_wr_i && hit && ofs == OFS_ENABLES && !lc7
    && !enh_enable_i |=> int_enables_o[7:4] == $past(int_enables_o[7:4]))
    else $error("upper enables changed while locked");
  tx_ready_a: assert property (fifo_mode_i && int_enables_o[EN_TX_READY]
    && DEPTH - tx_level_o > tx_trigger_i |-> int_req_tx_ready_o)
    else $error("transmit ready request missing");
  clk_gate_a: assert property (osc_enable_o == !asleep_o
    && chan_clk_en_o == !asleep_o) else $error("clock gating disagrees with sleep");
  wake_tx_a: assert property (asleep_o ##0 tx_wr_s |=> !asleep_o)
    else $error("transmit load did not wake");
endmodule : uart_front_checker

bind uart_holding_and_int_enable uart_front_checker #(.DEPTH(DEPTH), .AW(AW)) chk_inst (.*);

// ---- test/uart_holding_and_int_enable_bench.sv ----
/*
  Self-checking bench for the holding ports, divisor and enables.
  Assumes the host model for register traffic; the bench plays the line side.
*/
`timescale 1ns/1ps
module uart_holding_and_int_enable_bench;
  import uart_front_pkg::*;
  localparam int         D  = 8;
  localparam logic [1:0] CH = 2'b01;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, soft_rst_i = 1'b0, enh_enable_i = 1'b0;
  logic fifo_mode_i = 1'b1, rx_push_i = 1'b0, tx_pop_i = 1'b0, rx_pin_i = 1'b1;
  logic int_pending_i = 1'b0, reg_rd_i, reg_wr_i, wr_nack_o, reg_rvalid_o, tx_valid_o;
  logic asleep_o, osc_enable_o, chan_clk_en_o, nack;
  logic int_req_rx_ready_o, int_req_tx_ready_o, int_req_line_err_o, int_req_modem_o;
  logic int_req_xoff_o, int_req_rts_dtr_o, int_req_cts_dsr_o;
  logic [1:0] chan_id_i = CH;
  logic [3:0] modem_pins_i = 4'hF;
  logic [3:0] rx_level_o, tx_level_o;
  logic [5:0] src = 6'h00;
  logic [6:0] tx_trigger_i = 7'h04;
  logic [7:0] line_control_i = 8'h00, rx_byte_i = 8'h00, sub_addr_i, reg_wdata_i, b;
  logic [7:0] reg_rdata_o, tx_byte_o, divisor_low_o, int_enables_o;
  logic [8:0] e;
  logic [8:0] rd_q[$];
  logic [7:0] tx_q[$];
  int mismatches = 0, num_checks = 0, cyc = 0, i, n;
  wire src_cts_dsr_i = src[5], src_rts_dtr_i = src[4], src_xoff_i = src[3];
  wire src_modem_i = src[2], src_line_err_i = src[1], src_rx_ready_i = src[0];
  uart_holding_and_int_enable #(.DEPTH(D)) uart_holding_and_int_enable_inst (.*);
  host_model host_model_inst (.clk_i(clk_i), .wr_nack_i(wr_nack_o), .sub_addr_o(sub_addr_i),
    .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // ------------------------------
  // Compare and close
  // ------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic acc(input logic rd, input logic [3:0] ofs, input logic [7:0] d);
    host_model_inst.access(rd, ofs, d, CH, nack);
  endtask : acc
  task automatic wait_sleep(input logic v);
    for (n = 0; n < 20 && asleep_o !== v; n++) @(posedge clk_i);
    #1;
  endtask : wait_sleep
  always @(posedge clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      e = rd_q.pop_front();
      if (e[8] !== 1'b1) chk("read data", e[7:0], reg_rdata_o);
    end
    if (tx_pop_i === 1'b1 && tx_valid_o === 1'b1) begin
      chk("tx byte", tx_q.pop_front(), tx_byte_o);
    end
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      conclude();
    end
  end
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    void'($urandom(58));
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("divisor", DIV_LOW_RESET, divisor_low_o);
    chk("enables", EN_RESET, int_enables_o);
    for (i = 0; i < 5; i++) begin
      b = 8'($urandom);
      @(posedge clk_i);
      rx_push_i <= 1'b1;
      rx_byte_i <= b;
      rd_q.push_back({1'b0, b});
    end
    @(posedge clk_i);
    rx_push_i <= 1'b0;
    for (i = 0; i < 6; i++) begin
      if (i == 5) rd_q.push_back(9'h100);
      acc(1'b1, OFS_HOLDING, 8'h00);
    end
    chk("rx level", 8'h00, 8'(rx_level_o));
    for (i = 0; i <= D; i++) begin
      b = 8'($urandom);
      if (i < D) tx_q.push_back(b);
      acc(1'b0, OFS_HOLDING, b);
      chk("nack", {7'h00, i == D}, {7'h00, nack});
    end
    chk("tx level", 8'(D), 8'(tx_level_o));
    // Pops are spaced and random so the far side stalls between bytes.
    for (n = 0; n < 400 && tx_q.size() > 0; n++) begin
      @(posedge clk_i);
      tx_pop_i <= tx_valid_o === 1'b1 && tx_pop_i === 1'b0 && $urandom_range(0, 1);
    end
    @(posedge clk_i);
    tx_pop_i <= 1'b0;
    line_control_i <= 8'h80;
    acc(1'b0, OFS_HOLDING, 8'h5A);
    chk("divisor", 8'h5A, divisor_low_o);
    line_control_i <= LC_LOCK_CODE;
    acc(1'b0, OFS_HOLDING, 8'h77);
    chk("divisor", 8'h5A, divisor_low_o);
    chk("tx level", 8'h00, 8'(tx_level_o));
    line_control_i <= 8'h00;
    acc(1'b0, OFS_ENABLES, 8'hFF);
    rd_q.push_back({1'b0, EN_LOW_MASK});
    acc(1'b1, OFS_ENABLES, 8'h00);
    enh_enable_i <= 1'b1;
    acc(1'b0, OFS_ENABLES, 8'hA5);
    src <= 6'h3F;
    rd_q.push_back(9'h0A5);
    acc(1'b1, OFS_ENABLES, 8'h00);
    chk("requests", 8'h2B, {2'b00, int_req_cts_dsr_o, int_req_rts_dtr_o, int_req_xoff_o,
        int_req_modem_o, int_req_line_err_o, int_req_rx_ready_o});
    src <= 6'h00;
    acc(1'b0, OFS_ENABLES, 8'h10);
    wait_sleep(1'b1);
    chk("asleep", 8'h01, {7'h00, asleep_o});
    chk("osc", 8'h00, {7'h00, osc_enable_o});
    chk("chan clk", 8'h00, {7'h00, chan_clk_en_o});
    tx_q.push_back(8'h3C);
    acc(1'b0, OFS_HOLDING, 8'h3C);
    wait_sleep(1'b0);
    chk("asleep", 8'h00, {7'h00, asleep_o});
    @(posedge clk_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    tx_q.delete();
    #1;
    chk("enables", EN_RESET, int_enables_o);
    chk("tx level", 8'h00, 8'(tx_level_o));
    chk("divisor", 8'h5A, divisor_low_o);
    acc(1'b0, OFS_ENABLES, 8'h10);
    wait_sleep(1'b1);
    rx_pin_i <= 1'b0;
    wait_sleep(1'b0);
    chk("asleep", 8'h00, {7'h00, asleep_o});
    // Non-buffered mode: ready only while the transmit side is empty.
    fifo_mode_i <= 1'b0;
    acc(1'b0, OFS_ENABLES, 8'h02);
    chk("tx ready", 8'h01, {7'h00, int_req_tx_ready_o});
    acc(1'b0, OFS_HOLDING, 8'h11);
    chk("tx ready", 8'h00, {7'h00, int_req_tx_ready_o});
    repeat (3) @(posedge clk_i);
    conclude();
  end
endmodule : uart_holding_and_int_enable_bench
